// ### rtl/hbp_pkg.sv
// Package for the host bus port: types, register map, field layout.
// Assumes a single 125 MHz clock domain and no imports by users.
package hbp_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Register map (word index = addr[6:1])
    // ------------------------------------------------------------
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_STATUS = 6'h01;
    localparam logic [5:0] REG_IRQ_STAT = 6'h02;
    localparam logic [5:0] REG_IRQ_MASK_A = 6'h03;
    localparam logic [5:0] REG_IRQ_MASK_B = 6'h04;
    localparam logic [5:0] REG_FIFO_LEVEL = 6'h05;
    localparam logic [5:0] REG_STRAPS = 6'h06;
    localparam logic [5:0] REG_FIFO_POP = 6'h07;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_POL_A = 0;
    localparam int CTRL_POL_B = 1;
    localparam int CTRL_FLUSH = 2;
    localparam int IRQ_W = 4;
    localparam int EV_TX_WORD = 0;
    localparam int EV_TX_FULL = 1;
    localparam int EV_TX_EMPTY = 2;
    localparam int EV_TX_DROP = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic addr_multiplex_strap;
        logic strobe_style_strap;
        logic strobe_polarity_strap;
        logic data_width_strap;
        logic byte_order_strap;
    } hbp_straps_t;

    typedef struct packed {
        logic read_or_data_strobe;
        logic write_or_direction;
        logic addr_latch_en_low;
        logic addr_latch_en_high;
        logic upper_byte_en_n;
        logic ram_select_a_n;
        logic ram_select_b_n;
        logic reg_select_n;
        logic reg_select_p;
        logic tx_fifo_dma_ack_n;
    } hbp_ctl_pins_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_READ,
        BUS_WRITE
    } hbp_bus_st_t;

endpackage : hbp_pkg

// ### rtl/hbp_sync.sv
// Two-stage synchroniser for a vector of pin inputs.
// Assumes the inputs are asynchronous to ref_clk_i.
`timescale 1ns/1ns
module hbp_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,   // Clock
    input wire logic rstn_i,      // Async reset, active low
    input wire logic [W-1:0] d_i, // Asynchronous input
    output logic [W-1:0] q_o      // Synchronised output
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule : hbp_sync

// ### rtl/hbp_host_port.sv
// Host parallel bus port: strap-configured strobes, address latch,
// byte steering, transmit FIFO with DMA handshake, two interrupts.
// Assumes all pins are asynchronous and strobes last >= 3 clocks.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module hbp_host_port #(
    parameter int DEPTH = hbp_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk_i,                 // 125 MHz clock
    input wire logic rstn_i,                    // Async reset, active low
    input wire hbp_pkg::hbp_straps_t straps_i,  // Static strap pins
    input wire hbp_pkg::hbp_ctl_pins_t ctl_i,   // Bus control pins
    input wire logic [15:0] addr_i,             // Address pins (mux=0)
    input wire logic [15:0] data_i,             // Data bus input
    input wire logic tx_pop_i,                  // Serial side takes word
    output logic [15:0] data_o,                 // Data bus output
    output logic [15:0] data_oe_o,              // Data bus drive enable
    output logic [15:0] latch_addr_o,           // Latched address out
    output logic [15:0] tx_data_o,              // FIFO head word
    output logic tx_valid_o,                    // FIFO not empty
    output logic ram_req_o,                     // RAM access strobe
    output logic ram_we_o,                      // RAM access is write
    output logic [15:0] ram_addr_o,             // RAM word address
    output logic [15:0] ram_wdata_o,            // RAM write data
    output logic [1:0] ram_be_o,                // RAM byte enables
    output logic tx_fifo_dma_request_o,         // DMA request, high
    output logic irq_out_a_o,                   // Interrupt A
    output logic irq_out_b_o                    // Interrupt B
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam int IW = hbp_pkg::IRQ_W;
    localparam int NS = $bits(hbp_pkg::hbp_ctl_pins_t)
                        + $bits(hbp_pkg::hbp_straps_t) + 32;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    hbp_pkg::hbp_straps_t st;
    hbp_pkg::hbp_ctl_pins_t cp;
    logic [15:0] a_s;
    logic [15:0] d_s;

    hbp_sync #(.W(NS)) u_sync (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .d_i({straps_i, ctl_i, addr_i, data_i}),
        .q_o({st, cp, a_s, d_s})
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        hbp_pkg::hbp_bus_st_t bus;
        logic [15:0] alat;
        logic [15:0] ctrl;
        logic [IW-1:0] istat;
        logic [IW-1:0] mask_a;
        logic [IW-1:0] mask_b;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
        logic [15:0] dout;
        logic [15:0] doe;
        logic ram_req;
        logic ram_we;
        logic [15:0] ram_addr;
        logic [15:0] ram_wdata;
        logic [1:0] ram_be;
        logic dreq;
        logic irq_a;
        logic irq_b;
        logic txv;
        logic [1:0] settle;
    } hbp_state_t;

    hbp_state_t s_reg;
    hbp_state_t s_next;
    logic [15:0] fifo_mem [DEPTH];

    // ------------------------------------------------------------
    // Strobe decode
    // ------------------------------------------------------------
    logic rd_act;
    logic wr_act;
    logic ds_on;
    logic [15:0] eff_addr;
    logic reg_sel;
    logic ram_sel;
    logic dma_wr;
    logic [5:0] widx;
    logic [15:0] wdat;
    logic [1:0] lanes;
    logic even_is_low;

    always_comb begin
        // Data strobe level per polarity strap
        ds_on = st.strobe_polarity_strap ? cp.read_or_data_strobe
                                         : !cp.read_or_data_strobe;
        if (st.strobe_style_strap) begin
            rd_act = ds_on && cp.write_or_direction;
            wr_act = ds_on && !cp.write_or_direction;
        end else begin
            rd_act = !cp.read_or_data_strobe;
            wr_act = !cp.write_or_direction;
        end
        // Synced pins read all-zero until loaded; that looks like strobes
        if (!s_reg.settle[1]) begin
            rd_act = 1'b0;
            wr_act = 1'b0;
        end
        // Latched or plain address
        eff_addr = st.addr_multiplex_strap ? s_reg.alat : a_s;
        reg_sel = !cp.reg_select_n && cp.reg_select_p;
        ram_sel = !cp.ram_select_a_n && !cp.ram_select_b_n;
        dma_wr = !cp.tx_fifo_dma_ack_n;
        widx = eff_addr[6:1];
        even_is_low = !st.byte_order_strap;
        // Lane choice: 16-bit uses upper byte enable
        if (st.data_width_strap) begin
            lanes = {!cp.upper_byte_en_n, 1'b1};
            wdat = d_s;
        end else begin
            // 8-bit: even address maps per byte order
            if (eff_addr[0] ^ even_is_low) begin
                lanes = 2'b01;
            end else begin
                lanes = 2'b10;
            end
            wdat = {d_s[7:0], d_s[7:0]};
        end
    end

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    logic [15:0] rword;
    logic [15:0] rbus;

    always_comb begin
        unique case (widx)
            hbp_pkg::REG_CTRL: rword = s_reg.ctrl;
            hbp_pkg::REG_STATUS:
                rword = {13'h0000, s_reg.cnt == CW'(DEPTH),
                         s_reg.cnt == '0, s_reg.dreq};
            hbp_pkg::REG_IRQ_STAT: rword = 16'(s_reg.istat);
            hbp_pkg::REG_IRQ_MASK_A: rword = 16'(s_reg.mask_a);
            hbp_pkg::REG_IRQ_MASK_B: rword = 16'(s_reg.mask_b);
            hbp_pkg::REG_FIFO_LEVEL: rword = 16'(s_reg.cnt);
            hbp_pkg::REG_STRAPS: rword = 16'(st);
            default: rword = 16'h0000;
        endcase
        if (st.data_width_strap) begin
            rbus = rword;
        end else if (lanes[1]) begin
            rbus = {8'h00, rword[15:8]};
        end else begin
            rbus = {8'h00, rword[7:0]};
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic push;
    logic pop;
    logic [IW-1:0] ev;
    logic [15:0] merged;

    always_comb begin
        s_next = s_reg;
        push = 1'b0;
        pop = 1'b0;
        ev = '0;
        s_next.ram_req = 1'b0;
        if (!s_reg.settle[1]) s_next.settle = s_reg.settle + 2'd1;
        // Transparent latch while enables high
        if (st.addr_multiplex_strap && s_reg.settle[1]) begin
            if (cp.addr_latch_en_low) begin
                s_next.alat[7:0] = d_s[7:0];
            end
            if (cp.addr_latch_en_high) begin
                s_next.alat[15:8] = d_s[15:8];
            end
        end
        merged = s_reg.ctrl;
        if (lanes[0]) merged[7:0] = wdat[7:0];
        if (lanes[1]) merged[15:8] = wdat[15:8];
        unique case (s_reg.bus)
            hbp_pkg::BUS_IDLE: begin
                if (wr_act) begin
                    s_next.bus = hbp_pkg::BUS_WRITE;
                    if (dma_wr) begin
                        // DMA write wins over address and selects
                        if (s_reg.cnt != CW'(DEPTH)) begin
                            push = 1'b1;
                            ev[hbp_pkg::EV_TX_WORD] = 1'b1;
                        end else begin
                            ev[hbp_pkg::EV_TX_DROP] = 1'b1;
                        end
                    end else if (reg_sel) begin
                        unique case (widx)
                            hbp_pkg::REG_CTRL: s_next.ctrl = merged;
                            hbp_pkg::REG_IRQ_MASK_A:
                                s_next.mask_a = wdat[IW-1:0];
                            hbp_pkg::REG_IRQ_MASK_B:
                                s_next.mask_b = wdat[IW-1:0];
                            hbp_pkg::REG_FIFO_POP: pop = 1'b1;
                            default: ;
                        endcase
                        if (widx == hbp_pkg::REG_IRQ_STAT) begin
                            s_next.istat = s_reg.istat & ~wdat[IW-1:0];
                        end
                    end else if (ram_sel) begin
                        s_next.ram_req = 1'b1;
                        s_next.ram_we = 1'b1;
                        s_next.ram_addr = {1'b0, eff_addr[15:1]};
                        s_next.ram_wdata = wdat;
                        s_next.ram_be = lanes;
                    end
                end else if (rd_act) begin
                    s_next.bus = hbp_pkg::BUS_READ;
                    if (reg_sel) begin
                        s_next.dout = rbus;
                        s_next.doe = st.data_width_strap ?
                                     {{8{lanes[1]}}, 8'hff} : 16'h00ff;
                    end else if (ram_sel) begin
                        s_next.ram_req = 1'b1;
                        s_next.ram_we = 1'b0;
                        s_next.ram_addr = {1'b0, eff_addr[15:1]};
                        s_next.ram_be = lanes;
                    end
                end
            end
            hbp_pkg::BUS_READ: begin
                if (!rd_act) begin
                    s_next.bus = hbp_pkg::BUS_IDLE;
                    s_next.doe = 16'h0000;
                end
            end
            hbp_pkg::BUS_WRITE: begin
                if (!wr_act) s_next.bus = hbp_pkg::BUS_IDLE;
            end
            default: s_next.bus = hbp_pkg::BUS_IDLE;
        endcase
        if (s_reg.ctrl[hbp_pkg::CTRL_FLUSH]) begin
            s_next.ctrl[hbp_pkg::CTRL_FLUSH] = 1'b0;
            s_next.wp = '0;
            s_next.rp = '0;
            s_next.cnt = '0;
            push = 1'b0;
        end else begin
            if (tx_pop_i && s_reg.cnt != '0) pop = 1'b1;
            else if (s_reg.cnt == '0) pop = 1'b0;
            if (push) s_next.wp = PW'(s_reg.wp + 1'b1);
            if (pop) s_next.rp = PW'(s_reg.rp + 1'b1);
            s_next.cnt = CW'(s_reg.cnt + CW'(push) - CW'(pop));
        end
        if (push && s_next.cnt == CW'(DEPTH)) begin
            ev[hbp_pkg::EV_TX_FULL] = 1'b1;
        end
        if (pop && s_next.cnt == '0) ev[hbp_pkg::EV_TX_EMPTY] = 1'b1;
        // Set beats clear in the same cycle
        s_next.istat = s_next.istat | ev;
        // Request falls as the filling write starts
        s_next.dreq = s_next.cnt != CW'(DEPTH);
        s_next.txv = s_next.cnt != '0;
        // Programmable source and level per output
        s_next.irq_a = (|(s_next.istat & s_next.mask_a))
                       ^ s_next.ctrl[hbp_pkg::CTRL_POL_A];
        s_next.irq_b = (|(s_next.istat & s_next.mask_b))
                       ^ s_next.ctrl[hbp_pkg::CTRL_POL_B];
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_reg <= '0;
            s_reg.bus <= hbp_pkg::BUS_IDLE;
            s_reg.ctrl <= hbp_pkg::CTRL_RST;
            s_reg.mask_a <= hbp_pkg::MASK_RST;
            s_reg.mask_b <= hbp_pkg::MASK_RST;
            s_reg.dreq <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Storage has no reset; the head slot is read at any count and is valid only while tx_valid_o is high
    always_ff @(posedge ref_clk_i) begin
        if (push) fifo_mem[s_reg.wp] <= wdat;
    end

    logic [15:0] head_reg;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            head_reg <= 16'h0000;
        end else begin
            head_reg <= fifo_mem[s_next.rp];
        end
    end

    assign data_o = s_reg.dout;
    assign data_oe_o = s_reg.doe;
    assign latch_addr_o = s_reg.alat;
    assign tx_data_o = head_reg;
    assign tx_valid_o = s_reg.txv;
    assign ram_req_o = s_reg.ram_req;
    assign ram_we_o = s_reg.ram_we;
    assign ram_addr_o = s_reg.ram_addr;
    assign ram_wdata_o = s_reg.ram_wdata;
    assign ram_be_o = s_reg.ram_be;
    assign tx_fifo_dma_request_o = s_reg.dreq;
    assign irq_out_a_o = s_reg.irq_a;
    assign irq_out_b_o = s_reg.irq_b;
endmodule : hbp_host_port

// ### tb/hbp_host_port_asserts.sv
// Checker for the host bus port, bound to the port's top module.
// Assumes the bench holds pins steady around every strobe.
`timescale 1ns/1ns
module hbp_host_port_asserts #(
    parameter int DEPTH = 16
) (
    input wire logic ref_clk_i, // Clock
    input wire logic rstn_i, // Reset, active low
    input wire hbp_pkg::hbp_straps_t straps_i, // Straps
    input wire hbp_pkg::hbp_ctl_pins_t ctl_i, // Control pins
    input wire logic [15:0] addr_i, // Address pins
    input wire logic [15:0] data_i, // Data bus in
    input wire logic tx_pop_i, // FIFO pop
    input wire logic [15:0] data_oe_o, // Data drive enable
    input wire logic [15:0] latch_addr_o, // Latched address
    input wire logic tx_valid_o, // FIFO not empty
    input wire logic ram_req_o, // RAM strobe
    input wire logic [15:0] ram_addr_o, // RAM word address
    input wire logic [1:0] ram_be_o, // RAM byte enables
    input wire logic tx_fifo_dma_request_o, // DMA request
    input wire logic irq_out_a_o, // Interrupt A
    input wire logic irq_out_b_o // Interrupt B
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic mux;
    logic ale;
    logic rd_act;
    logic [15:0] src;
    assign mux = straps_i.addr_multiplex_strap;
    assign ale = ctl_i.addr_latch_en_low & ctl_i.addr_latch_en_high;
    assign src = mux ? latch_addr_o : addr_i;
    // Strobe pin level depends on style and polarity straps
    assign rd_act = straps_i.strobe_style_strap ?
        (ctl_i.read_or_data_strobe == straps_i.strobe_polarity_strap
         && ctl_i.write_or_direction) : !ctl_i.read_or_data_strobe;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_reset_outputs: assert property (
        $rose(rstn_i) |-> tx_fifo_dma_request_o && !irq_out_a_o
        && !irq_out_b_o) else $error("outputs wrong after reset");
    a_empty_room: assert property (
        !tx_valid_o |-> tx_fifo_dma_request_o)
        else $error("no request while fifo empty");
    a_pop_frees: assert property (
        tx_pop_i && !tx_fifo_dma_request_o |-> ##[1:3]
        tx_fifo_dma_request_o) else $error("pop did not free room");
    a_req_fall_ack: assert property (
        $fell(tx_fifo_dma_request_o) |-> !ctl_i.tx_fifo_dma_ack_n)
        else $error("request fell outside a dma write");
    a_latch_open: assert property (
        (mux && ale && $stable(data_i))[*4] |-> latch_addr_o == data_i)
        else $error("latch not transparent");
    a_latch_hold: assert property (
        (mux && !ctl_i.addr_latch_en_low && !ctl_i.addr_latch_en_high)[*4]
        |-> $stable(latch_addr_o)) else $error("latch did not hold");
    a_oe_on_read: assert property (
        $rose(data_oe_o[0]) |-> rd_act) else $error("drive without read");
    a_ram_addr_src: assert property (
        ram_req_o |-> ram_addr_o == {1'b0, src[15:1]})
        else $error("ram address from wrong source");
    a_byte_order: assert property (
        ram_req_o && !straps_i.data_width_strap |-> ram_be_o ==
        ((src[0] ^ straps_i.byte_order_strap) ? 2'b10 : 2'b01))
        else $error("wrong byte lane in 8-bit mode");
    a_upper_lane: assert property (
        ram_req_o && straps_i.data_width_strap |-> ram_be_o ==
        {!ctl_i.upper_byte_en_n, 1'b1}) else $error("wrong 16-bit lanes");
endmodule : hbp_host_port_asserts

bind hbp_host_port hbp_host_port_asserts #(.DEPTH(DEPTH)) i_chk (
    .ref_clk_i, .rstn_i, .straps_i, .ctl_i, .addr_i, .data_i, .tx_pop_i,
    .data_oe_o, .latch_addr_o, .tx_valid_o, .ram_req_o, .ram_addr_o,
    .ram_be_o, .tx_fifo_dma_request_o, .irq_out_a_o, .irq_out_b_o
);

// ### tb/hbp_host_model.sv
// Host processor and DMA controller model driving the port's pins.
// Assumes straps only change while the port is held in reset.
`timescale 1ns/1ns
module hbp_host_model (
    input wire logic ref_clk_i, // Clock
    input wire hbp_pkg::hbp_straps_t straps_i, // Straps
    input wire logic [15:0] rdata_i, // Read data from port
    output hbp_pkg::hbp_ctl_pins_t pins_o, // Control pins
    output logic [15:0] addr_o, // Address pins
    output logic [15:0] dat_o // Data bus to port
);
    // ------------------------------------------------------------
    // Pin sequencing
    // ------------------------------------------------------------
    initial pins_o = 10'h3fd;
    initial addr_o = 16'h0000;
    initial dat_o = 16'h0000;

    function automatic hbp_pkg::hbp_ctl_pins_t idle(
        input hbp_pkg::hbp_straps_t s);
        idle = 10'h3fd;
        idle.read_or_data_strobe = !(s.strobe_style_strap
            && s.strobe_polarity_strap);
        idle.addr_latch_en_low = !s.addr_multiplex_strap;
        idle.addr_latch_en_high = !s.addr_multiplex_strap;
    endfunction : idle

    task automatic park(input hbp_pkg::hbp_straps_t s);
        pins_o <= idle(s);
    endtask : park

    // Long setup and hold; the port syncs every pin through two flops
    task automatic acc(input logic we, input logic dma, input logic ram,
        input logic bhe_n, input logic [15:0] a, input logic [15:0] d,
        output logic [15:0] q);
        hbp_pkg::hbp_straps_t s;
        s = straps_i;
        pins_o.tx_fifo_dma_ack_n <= !dma;
        pins_o.reg_select_n <= dma | ram;
        pins_o.reg_select_p <= !(dma | ram);
        pins_o.ram_select_a_n <= !ram;
        pins_o.ram_select_b_n <= !ram;
        pins_o.upper_byte_en_n <= bhe_n;
        pins_o.write_or_direction <= !s.strobe_style_strap | !we;
        pins_o.addr_latch_en_low <= 1'b1;
        pins_o.addr_latch_en_high <= 1'b1;
        addr_o <= s.addr_multiplex_strap ? ~a : a;
        dat_o <= a;
        repeat (6) @(posedge ref_clk_i);
        pins_o.addr_latch_en_low <= !s.addr_multiplex_strap;
        pins_o.addr_latch_en_high <= !s.addr_multiplex_strap;
        repeat (4) @(posedge ref_clk_i);
        dat_o <= we ? d : ~a;
        repeat (4) @(posedge ref_clk_i);
        if (s.strobe_style_strap) begin
            pins_o.read_or_data_strobe <= s.strobe_polarity_strap;
        end else if (we) begin
            pins_o.write_or_direction <= 1'b0;
        end else begin
            pins_o.read_or_data_strobe <= 1'b0;
        end
        repeat (5) @(posedge ref_clk_i);
        q = rdata_i;
        pins_o <= idle(s);
        dat_o <= ~dat_o;
        repeat (4) @(posedge ref_clk_i);
    endtask : acc
endmodule : hbp_host_model

// ### tb/hbp_host_port_tb.sv
// Testbench for the host bus port: all strap settings, DMA fill and
// drop, interrupts. Assumes the host model and the bound checker.
`timescale 1ns/1ns
module hbp_host_port_tb;
    localparam int DEPTH = 4;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic tx_pop = 1'b0;
    hbp_pkg::hbp_straps_t straps = '0;
    hbp_pkg::hbp_ctl_pins_t pins;
    logic [15:0] addr, dat, rdata, oe, latch, tx_data, ram_addr, wdata;
    logic [15:0] q, lo, addr_seen, wdata_seen;
    logic [1:0] be, be_seen;
    logic tx_valid, ram_req, ram_we, req, irq_a, irq_b;
    int n_mismatch = 0;
    int checks = 0;

    always #4 ref_clk_i = ~ref_clk_i;

    hbp_host_model i_host (.ref_clk_i(ref_clk_i), .straps_i(straps),
        .rdata_i(rdata), .pins_o(pins), .addr_o(addr), .dat_o(dat));

    hbp_host_port #(.DEPTH(DEPTH)) i_dut (.ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i), .straps_i(straps), .ctl_i(pins), .addr_i(addr),
        .data_i(dat), .tx_pop_i(tx_pop), .data_o(rdata), .data_oe_o(oe),
        .latch_addr_o(latch), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
        .ram_req_o(ram_req), .ram_we_o(ram_we), .ram_addr_o(ram_addr),
        .ram_wdata_o(wdata), .ram_be_o(be), .tx_fifo_dma_request_o(req),
        .irq_out_a_o(irq_a), .irq_out_b_o(irq_b));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (ram_req === 1'b1) begin
            be_seen <= be;
            addr_seen <= ram_addr;
            wdata_seen <= wdata;
        end
    end

    task automatic give_verdict();
        $display("mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic chkb(input logic g, input logic e);
        chk({15'h0000, g}, {15'h0000, e});
    endtask : chkb

    function automatic logic [15:0] ra(input logic [5:0] w);
        return {9'h000, w, 1'b0};
    endfunction : ra

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        i_host.acc(1'b1, 1'b0, 1'b0, 1'b0, a, d, q);
    endtask : wr

    task automatic rdw(input logic [15:0] a, input logic [15:0] e);
        i_host.acc(1'b0, 1'b0, 1'b0, 1'b0, a, 16'h0000, q);
        chk({8'h00, q[7:0]}, e);
    endtask : rdw

    task automatic restart(input hbp_pkg::hbp_straps_t s);
        @(posedge ref_clk_i);
        rstn_i <= 1'b0;
        straps <= s;
        i_host.park(s);
        repeat (8) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
    endtask : restart

    initial begin
        #160000;
        n_mismatch++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 32; i++) begin
            restart(i[4:0]);
            chkb(req, 1'b1);
            lo = ra(hbp_pkg::REG_IRQ_MASK_A) | {15'h0000,
                straps.byte_order_strap & !straps.data_width_strap};
            wr(lo, 16'h0005);
            rdw(lo, 16'h0005);
            if (straps.addr_multiplex_strap) chk(latch, lo);
            i_host.acc(1'b1, 1'b0, 1'b1, 1'b1, 16'h0120, 16'habcd, q);
            chk({14'h0000, be_seen}, (!straps.data_width_strap &&
                straps.byte_order_strap) ? 16'h0002 : 16'h0001);
            chk(addr_seen, 16'h0090);
            chk(wdata_seen, straps.data_width_strap ? 16'habcd
                : 16'hcdcd);
        end
        // 16-bit path so FIFO words arrive whole
        restart(5'h02);
        wr(ra(hbp_pkg::REG_IRQ_MASK_A), 16'h0008);
        wr(ra(hbp_pkg::REG_IRQ_MASK_B), 16'h0002);
        for (int k = 0; k < DEPTH; k++) begin
            chkb(req, 1'b1);
            i_host.acc(1'b1, 1'b1, 1'b0, 1'b0, 16'hffff,
                {12'h100, k[3:0]}, q);
        end
        chkb(req, 1'b0);
        chkb(tx_valid, 1'b1);
        chkb(irq_b, 1'b1);
        chkb(irq_a, 1'b0);
        i_host.acc(1'b1, 1'b1, 1'b0, 1'b0, 16'hffff, 16'hdead, q);
        chkb(irq_a, 1'b1);
        rdw(ra(hbp_pkg::REG_FIFO_LEVEL), 16'h0004);
        chk(tx_data, 16'h1000);
        tx_pop <= 1'b1;
        @(posedge ref_clk_i);
        tx_pop <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        chkb(req, 1'b1);
        chk(tx_data, 16'h1001);
        wr(ra(hbp_pkg::REG_CTRL), 16'h0001);
        chkb(irq_a, 1'b0);
        wr(ra(hbp_pkg::REG_IRQ_STAT), 16'h000f);
        chkb(irq_a, 1'b1);
        chkb(irq_b, 1'b0);
        wr(ra(6'h3f), 16'h00ff);
        rdw(ra(6'h3f), 16'h0000);
        give_verdict();
    end
endmodule : hbp_host_port_tb
